// ---- verilog/shreg8_map.vh ----
`ifndef SHREG8_MAP_VH
`define SHREG8_MAP_VH

// chain geometry
`define SR_STAGES      8
`define SR_MSB         7
`define SR_NEXT_MSB    6
`define SR_CLEAR_VAL   8'h00

// filtered pin vector layout
`define PIN_W          13
`define PIN_CLK        0
`define PIN_GATE_BLK   1
`define PIN_ZERO_N     2
`define PIN_SHIFT_NLD  3
`define PIN_CHAIN_IN   4
`define PIN_DATA_LSB   5
`define PIN_DATA_MSB   12
`define PIN_RESET_VAL  13'h0000

// output stream buffer
`define FIFO_W         1
`define FIFO_DEPTH     8
`define FIFO_AW        3
`define FIFO_CW        4

`endif

// ---- verilog/shift_register8.v ----
// Summary of operation
// - while async_zero_n is low all eight stages and the serial output are held at zero, over all else.
// - with shift_not_load high each effective clock edge shifts chain_input_bit into the first stage.
// - with shift_not_load low the next effective edge loads input a into the first stage, h into the last.
// - during a parallel load the chain input bit is ignored.
// - state changes only on a rising edge of the pin clock or of clock_gate_block, seen through the NOR gate of the two.
// - while either clock input is high nothing is clocked and all stages hold.
// - with either clock input low the other one acts as the clock.
// - only the last stage is brought out; the first seven stay internal.
`timescale 1ns/1ps
`include "shreg8_map.vh"

module pin_filter #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             clk_sys_i,
   input  wire             reset_i,
   // pins
   input  wire [WIDTH-1:0] pin_i,
   output reg  [WIDTH-1:0] level_o
);
   reg [WIDTH-1:0] sync1;
   reg [WIDTH-1:0] sync2;
   reg [WIDTH-1:0] sync3;
   integer         k;

   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         sync1   <= {WIDTH{1'b0}};
         sync2   <= {WIDTH{1'b0}};
         sync3   <= {WIDTH{1'b0}};
         level_o <= {WIDTH{1'b0}};
      end else begin
         sync1 <= pin_i;
         sync2 <= sync1;
         sync3 <= sync2;
         // a change counts only once two settled samples agree
         for (k = 0; k < WIDTH; k = k + 1) begin
            if (sync2[k] == sync3[k]) begin
               level_o[k] <= sync3[k];
            end
         end
      end
   end
endmodule // pin_filter

module stream_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 8,
   parameter AW    = 3,
   parameter CW    = 4
) (
   // clock and reset
   input  wire             clk_sys_i,
   input  wire             reset_i,
   // fill side
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   // drain side, registered head
   output reg              out_valid_o,
   input  wire             out_ready_i,
   output reg  [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [CW-1:0]    count;
   wire            push;
   wire            pop;

   assign in_ready_o = (count != DEPTH[CW-1:0]);
   assign push       = in_valid_i & in_ready_o;
   assign pop        = (count != {CW{1'b0}}) & (~out_valid_o | out_ready_i);

   always @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         wr_ptr      <= {AW{1'b0}};
         rd_ptr      <= {AW{1'b0}};
         count       <= {CW{1'b0}};
         out_valid_o <= 1'b0;
         out_data_o  <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr     <= rd_ptr + 1'b1;
            out_data_o <= mem[rd_ptr];
         end
         if (pop) begin
            out_valid_o <= 1'b1;
         end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // stream_fifo

module shift_register8 (
   // clock and reset
   input  wire                  clk_sys_i,
   input  wire                  reset_i,
   // control pins
   input  wire                  shift_clock_i,
   input  wire                  clock_gate_block_i,
   input  wire                  async_zero_n_i,
   input  wire                  shift_not_load_i,
   // data pins
   input  wire                  chain_input_bit_i,
   input  wire [`SR_MSB:0]      parallel_data_i,
   // serial output
   output reg                   chain_output_bit_o,
   // buffered stream of output bits
   output wire                  stream_valid_o,
   input  wire                  stream_ready_i,
   output wire [`FIFO_W-1:0]    stream_bit_o
);
   wire [`PIN_W-1:0]  pin_raw;
   wire [`PIN_W-1:0]  pin;
   wire               gated_clock;
   wire               edge_rise;
   wire               event_due;
   wire               take;
   wire               fifo_ready;
   wire               fifo_ready_raw;
   wire               use_shift;
   wire               use_chain;
   wire [`SR_MSB:0]   use_data;
   reg  [`SR_MSB:0]   stages;
   reg  [`SR_MSB:0]   next_stages;
   reg                gated_q;
   reg                pending;
   reg                snap_shift;
   reg                snap_chain;
   reg  [`SR_MSB:0]   snap_data;
   reg                push;
   reg  [`FIFO_W-1:0] push_bit;

   assign pin_raw = {parallel_data_i, chain_input_bit_i, shift_not_load_i,
                     async_zero_n_i, clock_gate_block_i, shift_clock_i};

   // data and controls share one pipeline so they stay aligned with the edge
   pin_filter #(
      .WIDTH (`PIN_W)
   ) u_pins (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .pin_i     (pin_raw),
      .level_o   (pin)
   );

   // inverse of the NOR gate: it rises with the pin clock unless inhibit is already high
   assign gated_clock = pin[`PIN_CLK] | pin[`PIN_GATE_BLK];
   assign edge_rise   = gated_clock & ~gated_q;
   assign event_due   = edge_rise | pending;
   // a full buffer stalls the edge rather than losing it
   assign take        = event_due & fifo_ready & pin[`PIN_ZERO_N];

   assign use_shift = pending ? snap_shift : pin[`PIN_SHIFT_NLD];
   assign use_chain = pending ? snap_chain : pin[`PIN_CHAIN_IN];
   assign use_data  = pending ? snap_data  : pin[`PIN_DATA_MSB:`PIN_DATA_LSB];

   always @* begin
      if (use_shift) begin
         next_stages = {stages[`SR_NEXT_MSB:0], use_chain};
      end else begin
         next_stages = use_data;
      end
   end

   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         gated_q            <= 1'b0;
         pending            <= 1'b0;
         snap_shift         <= 1'b0;
         snap_chain         <= 1'b0;
         snap_data          <= `SR_CLEAR_VAL;
         stages             <= `SR_CLEAR_VAL;
         chain_output_bit_o <= 1'b0;
         push               <= 1'b0;
         push_bit           <= {`FIFO_W{1'b0}};
      end else begin
         gated_q <= gated_clock;
         push    <= 1'b0;
         if (~pin[`PIN_ZERO_N]) begin
            // clear wins over any edge, pending or new
            stages             <= `SR_CLEAR_VAL;
            chain_output_bit_o <= 1'b0;
            pending            <= 1'b0;
         end else if (take) begin
            stages             <= next_stages;
            chain_output_bit_o <= next_stages[`SR_MSB];
            push               <= 1'b1;
            push_bit           <= next_stages[`SR_MSB];
            pending            <= 1'b0;
         end else if (edge_rise & ~pending) begin
            // hold one edge while the buffer is full; later ones are dropped
            pending    <= 1'b1;
            snap_shift <= pin[`PIN_SHIFT_NLD];
            snap_chain <= pin[`PIN_CHAIN_IN];
            snap_data  <= pin[`PIN_DATA_MSB:`PIN_DATA_LSB];
         end
      end
   end

   // push is registered, so the ready term blocks a take while a push is still in flight
   stream_fifo #(
      .WIDTH (`FIFO_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW),
      .CW    (`FIFO_CW)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_ready_raw),
      .in_data_i   (push_bit),
      .out_valid_o (stream_valid_o),
      .out_ready_i (stream_ready_i),
      .out_data_o  (stream_bit_o)
   );

   assign fifo_ready = fifo_ready_raw & ~push;
endmodule // shift_register8

// ---- verilog/shift_register8_fix_note.v ----
`timescale 1ns/1ps

// ---- bench/pin_ctrl.sv ----
`timescale 1ns/1ps
module pin_ctrl (
   input  logic clk_sys_i, reset_i, gate_req_i,
   output logic shift_clock_o, clock_gate_block_o
);
   logic [3:0] ph;
   // free pin clock, 8 low then 8 high
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         ph <= 4'h0;
         shift_clock_o <= 1'b0;
         clock_gate_block_o <= 1'b0;
      end else begin
         ph <= ph + 4'h1;
         shift_clock_o <= ph[3];
         // inhibit moves mid-high only, else a false edge
         if (shift_clock_o && ph[3]) clock_gate_block_o <= gate_req_i;
      end
   end
endmodule // pin_ctrl

// ---- bench/shift_register8_sva.sv ----
`timescale 1ns/1ps
module sr8_chk (
   input logic       clk_sys_i, reset_i, shift_clock_i, clock_gate_block_i,
   input logic       async_zero_n_i, shift_not_load_i, chain_output_bit_o,
   input logic       stream_valid_o, stream_ready_i, stream_bit_o,
   input logic [7:0] parallel_data_i
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   property p_clr; !async_zero_n_i [*8] |-> !chain_output_bit_o; endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_inh; (clock_gate_block_i && async_zero_n_i) [*8] |=> $stable(chain_output_bit_o);
   endproperty
   a_inh: assert property (p_inh) else $error("inhibit");
   property p_hi; (shift_clock_i && async_zero_n_i) [*8] |=> $stable(chain_output_bit_o);
   endproperty
   a_hi: assert property (p_hi) else $error("clock high");
   property p_ld;
      $rose(shift_clock_i) && !clock_gate_block_i && !shift_not_load_i && async_zero_n_i
      |-> ##7 chain_output_bit_o == $past(parallel_data_i[7], 7);
   endproperty
   a_ld: assert property (p_ld) else $error("load");
   property p_push;
      $rose(shift_clock_i) && !clock_gate_block_i && async_zero_n_i |-> ##[4:9] stream_valid_o;
   endproperty
   a_push: assert property (p_push) else $error("push");
   property p_hold; stream_valid_o && !stream_ready_i |=> stream_valid_o && $stable(stream_bit_o);
   endproperty
   a_hold: assert property (p_hold) else $error("stream");
   // edge latency is five, so three back the pin clock is high and seven back low
   property p_cause; $changed(chain_output_bit_o) && $past(async_zero_n_i, 3)
      |-> $past(shift_clock_i, 3) && !$past(shift_clock_i, 7); endproperty
   a_cause: assert property (p_cause) else $error("cause");
   // a falling pin clock must never clock the stages
   property p_rise; $fell(shift_clock_i) |-> ##5 $stable(chain_output_bit_o); endproperty
   a_rise: assert property (p_rise) else $error("rise");
endmodule // sr8_chk
bind shift_register8 sr8_chk chk_u (.clk_sys_i, .reset_i, .shift_clock_i, .clock_gate_block_i,
   .async_zero_n_i, .shift_not_load_i, .chain_output_bit_o, .stream_valid_o, .stream_ready_i,
   .stream_bit_o, .parallel_data_i);

// ---- bench/shift_register8_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
   $display("Error %0t got %h exp %h", $time, a, b); end end
module shift_register8_bench;
   localparam logic [7:0] PAT = 8'h96;
   // leftover head bit, then the load and seven shifts of 8'hc5
   localparam logic [8:0] SEQ = {1'b0, 8'hc5};
   logic       clk_sys_i = 0, reset_i = 1, gate = 0, zero_n = 1, snl = 1, chain_input_bit = 0, rdy = 1;
   logic [7:0] pd = 8'h00;
   wire        sclk, inh, q, sv, sb;
   int         err_count = 0, cmp_count = 0, w;
   initial forever #5 clk_sys_i = ~clk_sys_i;
   pin_ctrl ctl_u (.clk_sys_i, .reset_i, .gate_req_i(gate), .shift_clock_o(sclk),
      .clock_gate_block_o(inh));
   shift_register8 dut_u (.clk_sys_i, .reset_i, .shift_clock_i(sclk), .clock_gate_block_i(inh),
      .async_zero_n_i(zero_n), .shift_not_load_i(snl), .chain_input_bit_i(chain_input_bit),
      .parallel_data_i(pd), .chain_output_bit_o(q), .stream_valid_o(sv),
      .stream_ready_i(rdy), .stream_bit_o(sb));
   task end_of_test;
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // pins change in the low phase and hold across the rising pin edge
   task step(input logic m, s, z, g, input logic [7:0] d);
      @(negedge sclk);
      @(posedge clk_sys_i);
      #1 {snl, chain_input_bit, zero_n, gate, pd} = {m, s, z, g, d};
      @(posedge sclk);
      repeat (7) @(posedge clk_sys_i);
      #1;
   endtask
   task t_load_shift;
      step(0, 1, 1, 0, PAT);
      `CHK(q, 1'b1)
      for (int i = 6; i >= 0; i--) begin
         step(1, 1, 1, 0, 8'h00);
         `CHK(q, PAT[i])
      end
      step(1, 0, 1, 0, 8'h00);
      `CHK(q, 1'b1)
   endtask
   task t_inhibit;
      // inhibit follows the request only in the high phase, so it lets the next rise through and masks the one after
      step(0, 0, 1, 1, 8'h7f);
      `CHK(q, 1'b0)
      repeat (2) begin
         step(1, 0, 1, 1, 8'h00);
         `CHK(q, 1'b0)
      end
      step(1, 0, 1, 0, 8'h00);
      `CHK(q, 1'b0)
      step(1, 0, 1, 0, 8'h00);
      `CHK(q, 1'b1)
   endtask
   task t_clear;
      step(0, 0, 1, 0, 8'hff);
      step(1, 1, 0, 0, 8'h00);
      `CHK(q, 1'b0)
      step(1, 1, 1, 0, 8'h00);
      `CHK(q, 1'b0)
   endtask
   task t_stream;
      // no idle pin period here, else a free edge would slip an extra bit in
      rdy = 0;
      step(0, 0, 1, 0, 8'hc5);
      repeat (7) step(1, 0, 1, 0, 8'h00);
      rdy = 1;
      for (int i = 8; i >= 0; i--) begin
         for (w = 0; w < 4 && sv !== 1'b1; w++) @(posedge clk_sys_i) #1;
         `CHK({sv, sb}, {1'b1, SEQ[i]})
         @(posedge clk_sys_i) #1;
      end
      repeat (3) @(posedge clk_sys_i);
      #1 `CHK(sv, 1'b0)
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_i);
      #1 reset_i = 0;
      `CHK(q, 1'b0)
      t_load_shift;
      t_inhibit;
      t_clear;
      t_stream;
      end_of_test;
   end
   initial begin
      #50000 err_count++;
      end_of_test;
   end
endmodule // shift_register8_bench
